/* rtl/codec_power_enable_regs.v */
// Behaviour
// - 0x0A holds beep path enable bit 7, drivers bits 3..0, reset 0.
// - 0x0B holds codec clock bit 14, DAC enables bits 5,4, reset 0.
// - 0x0B bit 13 high-pass enable resets to 1.
// - 0x0B bits 11,10 frequency loop and its oscillator, reset 0.
// - 0x0B bit 8 zero-cross slow clock enable, reset 0.
// - 0x0C bit 12 master enable at 0 holds codec registers in reset.
// - Power state machine can restore 0x0C enables to defaults.
// - 0x0C bit 11 rtc tick enable resets to 1; 0 stops clock.
// - 0x0C bit 10 crystal oscillator enable resets to 1.
// - Rtc and oscillator enables written only while key unlocked; restore ignores key.
// - Key-protected defaults come from a fixed mask option.
`include "codec_power_map.vh"
`default_nettype none
module codec_power_enable_regs #(
    // fixed mask option for the key-protected defaults
    parameter [15:0] MASK_OPTION_DEFAULT = `MASTER_RTC_RST
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // register access from control interface
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg reg_hit,
    // security key and power state machine
    input wire key_unlocked,
    input wire psm_restore,
    // output path enables
    output wire beep_path_en,
    output wire spk_right_drv_en,
    output wire spk_left_drv_en,
    output wire hp_right_drv_en,
    output wire hp_left_drv_en,
    // converter and clock enables
    output wire codec_clk_en,
    output wire highpass_en,
    output wire freq_loop_en,
    output wire freq_loop_osc_en,
    output wire zero_cross_slow_clk_en,
    output wire right_dac_en,
    output wire left_dac_en,
    output wire right_adc_en,
    output wire left_adc_en,
    // master and always-on enables
    output wire codec_master_en,
    output wire codec_regs_rst_n,
    output wire rtc_tick_en,
    output wire xtal_osc_en
);
    // ========================================================
    // reset release
    // registers leave reset two edges after rst_n rises
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ========================================================
    // decode
    wire sel_out = (reg_addr == `OUT_PATH_OFS);
    wire sel_conv = (reg_addr == `CONV_CLK_OFS);
    wire sel_mrtc = (reg_addr == `MASTER_RTC_OFS);
    wire wr_out = reg_wr && sel_out;
    wire wr_conv = reg_wr && sel_conv;
    wire wr_mrtc = reg_wr && sel_mrtc;

    wire [15:0] out_q;
    wire [15:0] conv_q;
    wire [15:0] mrtc_q;

    wire [15:0] mrtc_wbits;
    wire mrtc_restore;
    wire [15:0] mrtc_restore_val;
    wire [15:0] mrtc_restore_bits;

    // ========================================================
    // write and restore qualifiers
    // key-protected bits writable only while unlocked
    assign mrtc_wbits = key_unlocked ? 16'hFFFF : ~`KEY_PROT_MASK;
    // restore wins over a write in the same cycle
    assign mrtc_restore = psm_restore;
    // defaults of the key-protected bits come from the fixed option only
    assign mrtc_restore_val = MASK_OPTION_DEFAULT & `KEY_PROT_MASK;
    assign mrtc_restore_bits = `MASTER_RTC_MASK;

    // ========================================================
    // registers
    enable_reg #(
        .MASK(`OUT_PATH_MASK),
        .RST(`OUT_PATH_RST)
    ) u_out_path (
        .mclk(mclk),
        .rst_n(rst_s2_q),
        .wr_en(wr_out),
        .wr_data(reg_wdata),
        .wr_bits(16'hFFFF),
        .restore(1'b0),
        .restore_val(`OUT_PATH_RST),
        .restore_bits(16'h0000),
        .val_q(out_q)
    );

    enable_reg #(
        .MASK(`CONV_CLK_MASK),
        .RST(`CONV_CLK_RST)
    ) u_conv_clk (
        .mclk(mclk),
        .rst_n(rst_s2_q),
        .wr_en(wr_conv),
        .wr_data(reg_wdata),
        .wr_bits(16'hFFFF),
        .restore(1'b0),
        .restore_val(`CONV_CLK_RST),
        .restore_bits(16'h0000),
        .val_q(conv_q)
    );

    enable_reg #(
        .MASK(`MASTER_RTC_MASK),
        .RST(MASK_OPTION_DEFAULT & `KEY_PROT_MASK)
    ) u_master_rtc (
        .mclk(mclk),
        .rst_n(rst_s2_q),
        .wr_en(wr_mrtc),
        .wr_data(reg_wdata),
        .wr_bits(mrtc_wbits),
        .restore(mrtc_restore),
        .restore_val(mrtc_restore_val),
        .restore_bits(mrtc_restore_bits),
        .val_q(mrtc_q)
    );

    // ========================================================
    // enable outputs
    // all enables come straight from register flops
    // output path
    assign beep_path_en = out_q[`BEEP_PATH_BIT];
    assign spk_right_drv_en = out_q[`SPK_RIGHT_BIT];
    assign spk_left_drv_en = out_q[`SPK_LEFT_BIT];
    assign hp_right_drv_en = out_q[`HP_RIGHT_BIT];
    assign hp_left_drv_en = out_q[`HP_LEFT_BIT];

    // converter and clock
    assign codec_clk_en = conv_q[`CODEC_CLK_BIT];
    assign highpass_en = conv_q[`HIGHPASS_BIT];
    assign freq_loop_en = conv_q[`FREQ_LOOP_BIT];
    assign freq_loop_osc_en = conv_q[`FREQ_LOOP_OSC_BIT];
    assign zero_cross_slow_clk_en = conv_q[`ZC_SLOW_CLK_BIT];
    assign right_dac_en = conv_q[`RIGHT_DAC_BIT];
    assign left_dac_en = conv_q[`LEFT_DAC_BIT];
    assign right_adc_en = conv_q[`RIGHT_ADC_BIT];
    assign left_adc_en = conv_q[`LEFT_ADC_BIT];

    // master and always-on
    assign codec_master_en = mrtc_q[`CODEC_MASTER_BIT];
    // codec registers held in reset while the master enable is 0
    assign codec_regs_rst_n = codec_master_en;
    assign rtc_tick_en = mrtc_q[`RTC_TICK_BIT];
    assign xtal_osc_en = mrtc_q[`XTAL_OSC_BIT];

    // ========================================================
    // read data select, unassigned bits forced to zero
    wire [15:0] out_img;
    wire [15:0] conv_img;
    wire [15:0] mrtc_img;
    reg [15:0] rdata_d;
    reg hit_d;

    assign out_img = out_q & `OUT_PATH_MASK;
    assign conv_img = conv_q & `CONV_CLK_MASK;
    assign mrtc_img = mrtc_q & `MASTER_RTC_MASK;

    // unmapped offsets read zero and report no hit
    always @* begin
        rdata_d = 16'h0000;
        hit_d = 1'b0;
        case (reg_addr)
            `OUT_PATH_OFS: begin
                rdata_d = out_img;
                hit_d = 1'b1;
            end
            `CONV_CLK_OFS: begin
                rdata_d = conv_img;
                hit_d = 1'b1;
            end
            `MASTER_RTC_OFS: begin
                rdata_d = mrtc_img;
                hit_d = 1'b1;
            end
            default: begin
                rdata_d = 16'h0000;
                hit_d = 1'b0;
            end
        endcase
    end

    // ========================================================
    // read port, registered, held until the next read strobe
    always @(posedge mclk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            reg_rdata <= 16'h0000;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
            reg_hit <= hit_d;
        end
    end
endmodule // codec_power_enable_regs
`default_nettype wire

/* rtl/codec_power_map.vh */
`ifndef CODEC_POWER_MAP_VH
`define CODEC_POWER_MAP_VH
// ============================================================
// register offsets
`define OUT_PATH_OFS 8'h0A
`define CONV_CLK_OFS 8'h0B
`define MASTER_RTC_OFS 8'h0C
// ============================================================
// output_path_power fields
`define BEEP_PATH_BIT 7
`define SPK_RIGHT_BIT 3
`define SPK_LEFT_BIT 2
`define HP_RIGHT_BIT 1
`define HP_LEFT_BIT 0
`define OUT_PATH_MASK 16'h008F
`define OUT_PATH_RST 16'h0000
// ============================================================
// converter_clock_power fields
`define CODEC_CLK_BIT 14
`define HIGHPASS_BIT 13
`define FREQ_LOOP_BIT 11
`define FREQ_LOOP_OSC_BIT 10
`define ZC_SLOW_CLK_BIT 8
`define RIGHT_DAC_BIT 5
`define LEFT_DAC_BIT 4
`define RIGHT_ADC_BIT 3
`define LEFT_ADC_BIT 2
`define CONV_CLK_MASK 16'h6D3C
`define CONV_CLK_RST 16'h2000
// ============================================================
// master_and_rtc_power fields
`define CODEC_MASTER_BIT 12
`define RTC_TICK_BIT 11
`define XTAL_OSC_BIT 10
`define MASTER_RTC_MASK 16'h1C00
`define KEY_PROT_MASK 16'h0C00
`define MASTER_RTC_RST 16'h0C00
`endif

/* rtl/enable_reg.v */
`default_nettype none
// ============================================================
// masked register with async reset, write and default restore
module enable_reg #(
    parameter [15:0] MASK = 16'hFFFF,
    parameter [15:0] RST = 16'h0000
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // control
    input wire wr_en,
    input wire [15:0] wr_data,
    input wire [15:0] wr_bits,
    input wire restore,
    input wire [15:0] restore_val,
    input wire [15:0] restore_bits,
    // state
    output reg [15:0] val_q
);
    wire [15:0] val_d;
    wire [15:0] wmask;

    assign wmask = MASK & wr_bits & {16{wr_en}};
    assign val_d = restore ?
        ((val_q & ~restore_bits) | (restore_val & restore_bits)) :
        ((val_q & ~wmask) | (wr_data & wmask));

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            val_q <= RST & MASK;
        end else begin
            val_q <= val_d;
        end
    end
endmodule // enable_reg
`default_nettype wire

/* verification/codec_power_enable_regs_chk.sv */
`default_nettype none
module codec_power_chk (
    // bus and control
    input wire logic mclk, rst_n, reg_wr, reg_rd, reg_hit,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata,
    input wire logic key_unlocked, psm_restore,
    // enables
    input wire logic beep_path_en, spk_right_drv_en, spk_left_drv_en,
    input wire logic hp_right_drv_en, hp_left_drv_en, codec_clk_en,
    input wire logic highpass_en, freq_loop_en, freq_loop_osc_en,
    input wire logic zero_cross_slow_clk_en, right_dac_en, left_dac_en,
    input wire logic right_adc_en, left_adc_en, codec_master_en,
    input wire logic codec_regs_rst_n, rtc_tick_en, xtal_osc_en
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [4:0] op = {beep_path_en, spk_right_drv_en, spk_left_drv_en,
        hp_right_drv_en, hp_left_drv_en};
    wire [8:0] cc = {codec_clk_en, highpass_en, freq_loop_en,
        freq_loop_osc_en, zero_cross_slow_clk_en, right_dac_en,
        left_dac_en, right_adc_en, left_adc_en};
    wire [1:0] kp = {rtc_tick_en, xtal_osc_en};
    wire w0c = reg_wr && reg_addr == 8'h0C && !psm_restore;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // write and read behaviour
    out_path_wr_a: assert property (reg_wr && reg_addr == 8'h0A |=>
        op == $past({reg_wdata[7], reg_wdata[3:0]})) else $error("op");
    conv_wr_a: assert property (
        reg_wr && reg_addr == 8'h0B |=> cc == $past({reg_wdata[14:13],
        reg_wdata[11:10], reg_wdata[8], reg_wdata[5:2]})) else $error("cc");
    master_wr_a: assert property (w0c |=>
        codec_master_en == $past(reg_wdata[12])) else $error("master");
    master_rst_a: assert property (
        codec_regs_rst_n == codec_master_en) else $error("codec reset");
    key_wr_a: assert property (w0c && key_unlocked |=>
        kp == $past(reg_wdata[11:10])) else $error("key write");
    key_lock_a: assert property (!key_unlocked && !psm_restore |=>
        $stable(kp)) else $error("locked bits moved");
    psm_restore_a: assert property (psm_restore |=>
        {codec_master_en, kp} == 3'b011) else $error("restore");
    unmapped_rd_a: assert property (reg_rd &&
        !(reg_addr inside {8'h0A, 8'h0B, 8'h0C}) |=>
        reg_rdata == 16'h0000 && !reg_hit) else $error("unmapped read");
    cover property (w0c && !key_unlocked);
    cover property (psm_restore && reg_wr);
    cover property (reg_rd ##1 reg_hit);
endmodule // codec_power_chk
bind codec_power_enable_regs codec_power_chk chk_i (.*);
`default_nettype wire

/* verification/codec_power_enable_regs_bench.sv */
`default_nettype none
module codec_power_enable_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic key_unlocked = 0, psm_restore = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    wire [15:0] reg_rdata;
    wire reg_hit, beep_path_en, spk_right_drv_en, spk_left_drv_en;
    wire hp_right_drv_en, hp_left_drv_en, codec_clk_en, highpass_en;
    wire freq_loop_en, freq_loop_osc_en, zero_cross_slow_clk_en;
    wire right_dac_en, left_dac_en, right_adc_en, left_adc_en;
    wire codec_master_en, codec_regs_rst_n, rtc_tick_en, xtal_osc_en;
    int err_count = 0, tests_run = 0;
    codec_power_enable_regs uut (.*);
    always #2.5 mclk = ~mclk;
    // ============================================================
    // register image rebuilt from the enable outputs
    function automatic logic [15:0] img(input logic [7:0] a);
        case (a)
            8'h0A: img = {8'h00, beep_path_en, 3'b000, spk_right_drv_en,
                spk_left_drv_en, hp_right_drv_en, hp_left_drv_en};
            8'h0B: img = {1'b0, codec_clk_en, highpass_en, 1'b0,
                freq_loop_en, freq_loop_osc_en, 1'b0, zero_cross_slow_clk_en,
                2'b00, right_dac_en, left_dac_en, right_adc_en, left_adc_en,
                2'b00};
            default: img = {3'b000, codec_master_en, rtc_tick_en,
                xtal_osc_en, 10'h000};
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
        chk("hit", {15'h0, reg_hit}, {15'h0, a inside {8'h0A, 8'h0B, 8'h0C}});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, exp);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
        chk("image", img(a), exp);
        rd(a, exp);
    endtask
    // ============================================================
    // scenarios
    task automatic t_defaults();
        rd(8'h0A, 16'h0000);
        rd(8'h0B, 16'h2000);
        rd(8'h0C, 16'h0C00);
        rd(8'h0D, 16'h0000);
        chk("codec rst", {15'h0, codec_regs_rst_n}, 16'h0000);
    endtask
    task automatic t_masks();
        wr(8'h0A, 16'hFFFF, 16'h008F);
        wr(8'h0B, 16'hFFFF, 16'h6D3C);
        wr(8'h0B, 16'h000C, 16'h000C);
        wr(8'h0A, 16'h7F70, 16'h0000);
    endtask
    task automatic t_key();
        wr(8'h0C, 16'hF000, 16'h1C00);
        chk("codec rst", {15'h0, codec_regs_rst_n}, 16'h0001);
        @(posedge mclk);
        key_unlocked <= 1'b1;
        wr(8'h0C, 16'h1000, 16'h1000);
    endtask
    task automatic t_restore();
        @(posedge mclk);
        psm_restore <= 1'b1;
        wr(8'h0C, 16'h1000, 16'h0C00);
        chk("codec rst", {15'h0, codec_regs_rst_n}, 16'h0000);
        @(posedge mclk);
        psm_restore <= 1'b0;
        key_unlocked <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_defaults();
        t_masks();
        t_key();
        t_restore();
        end_of_test();
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule // codec_power_enable_regs_bench
`default_nettype wire
